// File: design/bbr_pkg.sv
/*
  Package of the bit-band alias remapper: region bases, masks, access
  size codes and controller states.
  Assumes a 32-bit byte address and a 32-bit lane-aligned data bus.
*/
package bbr_pkg;

  localparam logic [31:0] ALIAS_MASK      = 32'hFE00_0000;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] PER_ALIAS_BASE  = 32'h4200_0000;
  localparam logic [31:0] SRAM_BB_BASE    = 32'h2000_0000;
  localparam logic [31:0] PER_BB_BASE     = 32'h4000_0000;
  localparam logic [31:0] SRAM_BB_LAST    = 32'h2000_7FFF;

  // alias offset field positions: byte offset above, bit number below
  localparam int BYTE_OFS_HI = 24;
  localparam int BYTE_OFS_LO = 5;
  localparam int BIT_NUM_HI  = 4;
  localparam int BIT_NUM_LO  = 2;
  localparam int BYTE_OFS_W  = BYTE_OFS_HI - BYTE_OFS_LO + 1;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [31:0] ALIAS_ONE   = 32'h0000_0001;
  localparam logic [31:0] ALIAS_ZERO  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ  = 3'b001,
    ST_WAIT = 3'b010,
    ST_WREQ = 3'b011,
    ST_RESP = 3'b100
  } bbr_state_e;

endpackage

// File: design/bbr_dec_if.sv
/*
  Carrier between the remapper core and its address decoder.
  Assumes both ends sit on the same clock; the path is combinational.
*/
`timescale 1ns/100ps
`default_nettype none

interface bbr_dec_if;
  logic [31:0] addr;
  logic        instr;
  logic [1:0]  size;
  logic        alias_hit;
  logic        refuse;
  logic [31:0] tgt_addr;
  logic [4:0]  bitpos;
  logic [4:0]  wlane;

  modport dec (
    input  addr,
    input  instr,
    input  size,
    output alias_hit,
    output refuse,
    output tgt_addr,
    output bitpos,
    output wlane
  );

  modport core (
    output addr,
    output instr,
    output size,
    input  alias_hit,
    input  refuse,
    input  tgt_addr,
    input  bitpos,
    input  wlane
  );
endinterface

`default_nettype wire

// File: design/bbr_decode.sv
/*
  Address decoder of the bit-band alias remapper: classifies an upstream
  address and, for alias accesses, derives the bit-band target.
  Assumes the caller presents a stable request while it is looked at.
*/
`timescale 1ns/100ps
`default_nettype none

module bbr_decode (
  bbr_dec_if.dec dec
);

  logic                          sram_alias;
  logic                          per_alias;
  logic [31:0]                   tgt_byte;
  logic [bbr_pkg::BYTE_OFS_W-1:0] byte_ofs;
  logic [2:0]                    bit_num;

  assign sram_alias = (dec.addr & bbr_pkg::ALIAS_MASK)
                      == bbr_pkg::SRAM_ALIAS_BASE;
  assign per_alias  = (dec.addr & bbr_pkg::ALIAS_MASK)
                      == bbr_pkg::PER_ALIAS_BASE;

  // alias offset = byte offset * 32 + bit number * 4, inverted here
  assign byte_ofs = dec.addr[bbr_pkg::BYTE_OFS_HI:bbr_pkg::BYTE_OFS_LO];
  assign bit_num  = dec.addr[bbr_pkg::BIT_NUM_HI:bbr_pkg::BIT_NUM_LO];

  // each alias word lands on one bit of the low 1 MB of its region
  assign tgt_byte = (sram_alias ? bbr_pkg::SRAM_BB_BASE
                                : bbr_pkg::PER_BB_BASE)
                    | {{(32-bbr_pkg::BYTE_OFS_W){1'b0}}, byte_ofs};

  // fetches into the sram alias go through untouched
  assign dec.alias_hit = (sram_alias || per_alias) && !dec.instr;
  assign dec.refuse    = per_alias && dec.instr;

  // same size downstream, address aligned to that size
  always_comb
  begin
    unique case (dec.size)
      bbr_pkg::SIZE_WORD: dec.tgt_addr = {tgt_byte[31:2], 2'b00};
      bbr_pkg::SIZE_HALF: dec.tgt_addr = {tgt_byte[31:1], 1'b0};
      default:            dec.tgt_addr = tgt_byte;
    endcase
  end

  // little-endian lanes: byte n of a word sits in bits 8n+7..8n
  assign dec.bitpos = {tgt_byte[1:0], bit_num};
  assign dec.wlane  = {dec.addr[1:0], 3'b000};

endmodule

`default_nettype wire

// File: design/bbr_remap.sv
/*
  Bit-band alias remapper sitting between the core data bus master and
  the sram / peripheral fabric. One transaction is handled at a time.
  Assumes both buses run on core_clk_in, a lane-aligned 32-bit data bus
  and a downstream response no earlier than the cycle after acceptance.
*/
`timescale 1ns/100ps
`default_nettype none

// How it works
// - alias words map onto bit-band region bits
// - sram alias redirected to sram bit-band
// - peripheral alias redirected to peripheral bit-band
// - downstream access keeps original access size
// - offset equals byte times 32 plus bit times 4
// - bit number ranges zero through seven
// - alias write is read, modify, write back
// - sram alias fetches are not remapped
// - peripheral alias fetches are refused
// - written bit 0 sets target bit value
// - written bits 31 to 1 ignored
// - alias read returns zero or one
// - direct bit-band accesses pass unchanged
// - data lanes are little-endian
module bbr_remap (
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        up_valid_in,
  output logic             up_ready_out,
  input  wire logic        up_write_in,
  input  wire logic        up_instr_in,
  input  wire logic [31:0] up_addr_in,
  input  wire logic [1:0]  up_size_in,
  input  wire logic [31:0] up_wdata_in,
  output logic             up_rvalid_out,
  output logic [31:0]      up_rdata_out,
  output logic             up_err_out,
  output logic             dn_valid_out,
  input  wire logic        dn_ready_in,
  output logic             dn_write_out,
  output logic             dn_instr_out,
  output logic             dn_lock_out,
  output logic [31:0]      dn_addr_out,
  output logic [1:0]       dn_size_out,
  output logic [31:0]      dn_wdata_out,
  input  wire logic        dn_rvalid_in,
  input  wire logic [31:0] dn_rdata_in,
  input  wire logic        dn_err_in
);

  bbr_dec_if dec_bus ();

  bbr_pkg::bbr_state_e state_q;
  bbr_pkg::bbr_state_e state_d;

  logic        accept;
  logic        to_wreq;
  logic        rsp_done;
  logic        alias_q;
  logic        rmw_q;
  logic        wbit_q;
  logic [4:0]  bitpos_q;
  logic        dn_write_q;
  logic        dn_instr_q;
  logic        dn_lock_q;
  logic [31:0] dn_addr_q;
  logic [1:0]  dn_size_q;
  logic [31:0] dn_wdata_q;
  logic [31:0] up_rdata_q;
  logic        up_err_q;
  logic [31:0] merged;
  logic [31:0] alias_rdata;

  assign dec_bus.addr  = up_addr_in;
  assign dec_bus.instr = up_instr_in;
  assign dec_bus.size  = up_size_in;

  bbr_decode u_decode (
    .dec (dec_bus.dec)
  );

  assign accept  = up_valid_in && (state_q == bbr_pkg::ST_IDLE);
  // go on to the write half only after a clean read half
  assign to_wreq = (state_q == bbr_pkg::ST_WAIT) && dn_rvalid_in
                   && rmw_q && !dn_write_q && !dn_err_in;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      bbr_pkg::ST_IDLE:
      begin
        if (up_valid_in)
        begin
          state_d = dec_bus.refuse ? bbr_pkg::ST_RESP
                                   : bbr_pkg::ST_REQ;
        end
      end
      bbr_pkg::ST_REQ:
      begin
        if (dn_ready_in)
        begin
          state_d = bbr_pkg::ST_WAIT;
        end
      end
      bbr_pkg::ST_WAIT:
      begin
        if (dn_rvalid_in)
        begin
          // no idle state between halves, so nothing can slip in
          state_d = to_wreq ? bbr_pkg::ST_WREQ
                            : bbr_pkg::ST_RESP;
        end
      end
      bbr_pkg::ST_WREQ:
      begin
        if (dn_ready_in)
        begin
          state_d = bbr_pkg::ST_WAIT;
        end
      end
      bbr_pkg::ST_RESP:
      begin
        state_d = bbr_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = bbr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= bbr_pkg::ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // alias bookkeeping caught at acceptance
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      alias_q  <= 1'b0;
      rmw_q    <= 1'b0;
      wbit_q   <= 1'b0;
      bitpos_q <= 5'h00;
    end
    else if (accept)
    begin
      alias_q  <= dec_bus.alias_hit;
      rmw_q    <= dec_bus.alias_hit && up_write_in;
      // only the lowest bit of the written value counts
      wbit_q   <= up_wdata_in[dec_bus.wlane];
      bitpos_q <= dec_bus.bitpos;
    end
  end

  // replace only the target bit of what was read
  always_comb
  begin
    merged = dn_rdata_in;
    merged[bitpos_q] = wbit_q;
  end

  assign alias_rdata = dn_rdata_in[bitpos_q] ? bbr_pkg::ALIAS_ONE
                                             : bbr_pkg::ALIAS_ZERO;

  // fetch flag and size travel downstream as they came
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dn_instr_q <= 1'b0;
      dn_size_q  <= bbr_pkg::SIZE_WORD;
    end
    else if (accept && !dec_bus.refuse)
    begin
      dn_instr_q <= up_instr_in;
      dn_size_q  <= up_size_in;
    end
  end

  // plain and direct bit-band accesses keep their address
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dn_addr_q <= 32'h0000_0000;
    end
    else if (accept && !dec_bus.refuse)
    begin
      dn_addr_q <= dec_bus.alias_hit ? dec_bus.tgt_addr
                                     : up_addr_in;
    end
  end

  // an alias access always opens with a read; for an alias write the write half follows only a clean read half
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dn_write_q <= 1'b0;
    end
    else if (accept && !dec_bus.refuse)
    begin
      dn_write_q <= up_write_in && !dec_bus.alias_hit;
    end
    else if (to_wreq)
    begin
      dn_write_q <= 1'b1;
    end
  end

  // write data: passed through, or the merged word of the write half
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dn_wdata_q <= 32'h0000_0000;
    end
    else if (accept && !dec_bus.refuse)
    begin
      dn_wdata_q <= dec_bus.alias_hit ? 32'h0000_0000 : up_wdata_in;
    end
    else if (to_wreq)
    begin
      dn_wdata_q <= merged;
    end
  end

  // lock holds the fabric from read request through write response
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dn_lock_q <= 1'b0;
    end
    else if (accept && !dec_bus.refuse)
    begin
      dn_lock_q <= dec_bus.alias_hit && up_write_in;
    end
    else if (state_d == bbr_pkg::ST_RESP)
    begin
      dn_lock_q <= 1'b0;
    end
  end

  // the answer is due once the last downstream half has come back
  assign rsp_done = (state_q == bbr_pkg::ST_WAIT) && dn_rvalid_in
                    && !to_wreq;

  // error flag of the answer, held until the next answer
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      up_err_q <= 1'b0;
    end
    else if (accept && dec_bus.refuse)
    begin
      up_err_q <= 1'b1;
    end
    else if (rsp_done)
    begin
      up_err_q <= dn_err_in;
    end
  end

  // read data of the answer; writes and errors answer with zero
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      up_rdata_q <= bbr_pkg::RDATA_RESET;
    end
    else if (accept && dec_bus.refuse)
    begin
      up_rdata_q <= bbr_pkg::RDATA_RESET;
    end
    else if (rsp_done)
    begin
      if (dn_write_q || dn_err_in)
      begin
        up_rdata_q <= bbr_pkg::RDATA_RESET;
      end
      else
      begin
        up_rdata_q <= alias_q ? alias_rdata : dn_rdata_in;
      end
    end
  end

  assign up_ready_out  = (state_q == bbr_pkg::ST_IDLE);
  assign up_rvalid_out = (state_q == bbr_pkg::ST_RESP);
  assign up_rdata_out  = up_rdata_q;
  assign up_err_out    = up_err_q;
  assign dn_valid_out  = (state_q == bbr_pkg::ST_REQ)
                         || (state_q == bbr_pkg::ST_WREQ);
  assign dn_write_out  = dn_write_q;
  assign dn_instr_out  = dn_instr_q;
  assign dn_lock_out   = dn_lock_q;
  assign dn_addr_out   = dn_addr_q;
  assign dn_size_out   = dn_size_q;
  assign dn_wdata_out  = dn_wdata_q;

endmodule

`default_nettype wire

// File: bench/bbr_remap_props.sv
/*
  Port checker of the bit-band alias remapper.
  Assumes it is bound to bbr_remap and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module bbr_remap_props (
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  input wire logic        up_valid_in,
  input wire logic        up_ready_out,
  input wire logic        up_write_in,
  input wire logic        up_instr_in,
  input wire logic [31:0] up_addr_in,
  input wire logic [1:0]  up_size_in,
  input wire logic [31:0] up_wdata_in,
  input wire logic        up_rvalid_out,
  input wire logic [31:0] up_rdata_out,
  input wire logic        up_err_out,
  input wire logic        dn_valid_out,
  input wire logic        dn_ready_in,
  input wire logic        dn_write_out,
  input wire logic        dn_instr_out,
  input wire logic        dn_lock_out,
  input wire logic [31:0] dn_addr_out,
  input wire logic [1:0]  dn_size_out,
  input wire logic [31:0] dn_wdata_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic       al_q;
  logic       rd_q;
  logic       wb_q;
  logic [4:0] pos_q;
  wire logic  tk  = up_valid_in && up_ready_out;
  wire logic  sal = (up_addr_in & bbr_pkg::ALIAS_MASK)
                    == bbr_pkg::SRAM_ALIAS_BASE;
  wire logic  pal = (up_addr_in & bbr_pkg::ALIAS_MASK)
                    == bbr_pkg::PER_ALIAS_BASE;
  function automatic logic [31:0] tgt(input logic [31:0] x,
                                      input logic [1:0] s);
    logic [31:0] t;
    t = (x[30] ? bbr_pkg::PER_BB_BASE : bbr_pkg::SRAM_BB_BASE)
        + {12'h000, x[24:5]};
    tgt = t & ~((s == bbr_pkg::SIZE_WORD) ? 32'h3 :
                (s == bbr_pkg::SIZE_HALF) ? 32'h1 : 32'h0);
  endfunction
  // remembers what the current transaction should do to the target bit
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      al_q  <= 1'b0;
      rd_q  <= 1'b0;
      wb_q  <= 1'b0;
      pos_q <= 5'h00;
    end
    else if (tk)
    begin
      al_q  <= (sal || pal) && !up_instr_in;
      rd_q  <= !up_write_in;
      wb_q  <= up_wdata_in[{up_addr_in[1:0], 3'h0}];
      pos_q <= {up_addr_in[6:5], up_addr_in[4:2]};
    end
  AST_REMAP: assert property (
    tk && (sal || pal) && !up_instr_in |=> dn_valid_out
    && dn_addr_out == tgt($past(up_addr_in), $past(up_size_in)))
    else $error("alias target address mismatch");
  AST_SIZE: assert property (
    tk && !(pal && up_instr_in) |=> dn_size_out == $past(up_size_in))
    else $error("size not kept");
  AST_INSTR: assert property (
    tk && !(pal && up_instr_in) |=> dn_instr_out == $past(up_instr_in))
    else $error("fetch flag not kept");
  AST_PASS: assert property (
    tk && (!(sal || pal) || (sal && up_instr_in)) |=>
    dn_addr_out == $past(up_addr_in) && dn_wdata_out == $past(up_wdata_in)
    && dn_write_out == $past(up_write_in))
    else $error("pass-through altered");
  // the refused answer comes in the cycle right after the take
  AST_REFUSE: assert property (
    tk && pal && up_instr_in |=> !dn_valid_out && up_rvalid_out && up_err_out
    ##1 !dn_valid_out) else $error("alias fetch not refused");
  AST_RMW: assert property (
    tk && (sal || pal) && !up_instr_in && up_write_in
    |=> dn_valid_out && !dn_write_out && dn_lock_out)
    else $error("alias write did not start with a read");
  AST_WBIT: assert property (
    dn_valid_out && dn_write_out && al_q |-> dn_wdata_out[pos_q] == wb_q)
    else $error("target bit value wrong");
  AST_LOCK: assert property (
    dn_lock_out |-> !up_ready_out && al_q)
    else $error("lock held outside alias write");
  AST_ALRD: assert property (
    up_rvalid_out && al_q && rd_q && !up_err_out
    |-> up_rdata_out[31:1] == 31'h0) else $error("alias read not 0 or 1");
  AST_PULSE: assert property (up_rvalid_out |=> !up_rvalid_out && up_ready_out)
    else $error("answer not a single pulse");
  AST_HOLD: assert property (dn_valid_out && !dn_ready_in |=>
    dn_valid_out && $stable(dn_addr_out)) else $error("request dropped");
endmodule
`default_nettype wire

// File: bench/bbr_mem_model.sv
/*
  Downstream memory model: 256 words indexed by address bits 9:2; addresses from 0x6000_0000 up answer with an error.
  Assumes one request at a time; answers LAT cycles after accepting.
*/
`timescale 1ns/100ps
`default_nettype none
module bbr_mem_model #(
  parameter int LAT = 2
) (
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        stall_in,
  input  wire logic        dn_valid_in,
  output logic             dn_ready_out,
  input  wire logic        dn_write_in,
  input  wire logic [31:0] dn_addr_in,
  input  wire logic [1:0]  dn_size_in,
  input  wire logic [31:0] dn_wdata_in,
  output logic             dn_rvalid_out,
  output logic [31:0]      dn_rdata_out,
  output logic             dn_err_out
);
  logic [31:0] mem [256];
  logic [31:0] a_q;
  logic [31:0] d_q;
  logic [1:0]  s_q;
  logic        w_q;
  logic        busy_q;
  logic [3:0]  cnt_q;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0000_0000;
  assign dn_ready_out = !stall_in && !busy_q;
  always @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      busy_q        <= 1'b0;
      dn_rvalid_out <= 1'b0;
      dn_err_out    <= 1'b0;
      dn_rdata_out  <= 32'h0000_0000;
    end
    else
    begin
      dn_rvalid_out <= 1'b0;
      dn_err_out    <= 1'b0;
      // data lines do not hold outside a response
      dn_rdata_out  <= ~dn_rdata_out;
      if (dn_valid_in && dn_ready_out)
      begin
        busy_q <= 1'b1;
        cnt_q  <= 4'(LAT);
        a_q    <= dn_addr_in;
        d_q    <= dn_wdata_in;
        s_q    <= dn_size_in;
        w_q    <= dn_write_in;
      end
      else if (busy_q && cnt_q == 4'h1)
      begin
        busy_q        <= 1'b0;
        dn_rvalid_out <= 1'b1;
        dn_err_out    <= a_q[31:29] >= 3'h3;
        dn_rdata_out  <= w_q ? 32'h0000_0000 : mem[a_q[9:2]];
        for (int i = 0; i < 4; i++)
          if (w_q && (s_q == bbr_pkg::SIZE_WORD || i[1:0] == a_q[1:0] ||
              (s_q == bbr_pkg::SIZE_HALF && i[1] == a_q[1])))
            mem[a_q[9:2]][8*i +: 8] <= d_q[8*i +: 8];
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
endmodule
`default_nettype wire

// File: bench/bbr_remap_tb.sv
/*
  Self-checking bench of the bit-band alias remapper.
  Assumes the memory model stands downstream with a stalling ready.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module bbr_remap_tb;
  typedef struct {
    logic w; logic f; logic [31:0] a; logic [1:0] s;
    logic [31:0] wd; logic [31:0] rd; logic er;
  } bbr_row_s;
  bbr_row_s rows [14] = '{
    '{1'h1, 1'h0, 32'h2000_0000, 2'h2, 32'h1234_5678, 32'h0, 1'h0},
    '{1'h0, 1'h0, 32'h2200_0000, 2'h2, 32'h0, 32'h0, 1'h0},
    '{1'h0, 1'h0, 32'h2200_000C, 2'h2, 32'h0, 32'h1, 1'h0},
    '{1'h1, 1'h0, 32'h2200_001C, 2'h2, 32'hFF, 32'h0, 1'h0},
    '{1'h1, 1'h0, 32'h2200_000C, 2'h2, 32'h0E, 32'h0, 1'h0},
    '{1'h0, 1'h0, 32'h2000_0000, 2'h2, 32'h0, 32'h1234_56F0, 1'h0},
    '{1'h1, 1'h0, 32'h4200_00A8, 2'h0, 32'h01, 32'h0, 1'h0},
    '{1'h0, 1'h0, 32'h4000_0004, 2'h2, 32'h0, 32'h0000_0400, 1'h0},
    '{1'h0, 1'h0, 32'h4200_00A8, 2'h1, 32'h0, 32'h1, 1'h0},
    '{1'h1, 1'h0, 32'h23FF_FFFC, 2'h2, 32'hFFFF_FFFF, 32'h0, 1'h0},
    '{1'h0, 1'h0, 32'h200F_FFFC, 2'h2, 32'h0, 32'h8000_0000, 1'h0},
    '{1'h0, 1'h1, 32'h4200_0000, 2'h2, 32'h0, 32'h0, 1'h1},
    '{1'h0, 1'h1, 32'h2200_0000, 2'h2, 32'h0, 32'h1234_56F0, 1'h0},
    '{1'h0, 1'h0, 32'h6000_0000, 2'h2, 32'h0, 32'h0, 1'h1}};
  logic        core_clk_in = 1'b0, reset_n_in = 1'b0, stall = 1'b0;
  logic        up_valid_in = 1'b0, up_write_in = 1'b0, up_instr_in = 1'b0;
  logic [31:0] up_addr_in = 32'h0, up_wdata_in = 32'h0;
  logic [1:0]  up_size_in = 2'h2;
  logic        up_ready_out, up_rvalid_out, up_err_out, dn_valid_out;
  logic        dn_ready_in, dn_write_out, dn_lock_out, dn_rvalid_in;
  logic        dn_err_in;
  logic [31:0] up_rdata_out, dn_addr_out, dn_wdata_out, dn_rdata_in;
  logic [1:0]  dn_size_out;
  int          error_cnt = 0, checked = 0;
  bbr_remap u_dut (.core_clk_in, .reset_n_in, .up_valid_in, .up_ready_out,
    .up_write_in, .up_instr_in, .up_addr_in, .up_size_in, .up_wdata_in,
    .up_rvalid_out, .up_rdata_out, .up_err_out, .dn_valid_out, .dn_ready_in,
    .dn_write_out, .dn_instr_out(), .dn_lock_out, .dn_addr_out, .dn_size_out,
    .dn_wdata_out, .dn_rvalid_in, .dn_rdata_in, .dn_err_in);
  bbr_mem_model u_mem (.core_clk_in, .reset_n_in, .stall_in(stall),
    .dn_valid_in(dn_valid_out), .dn_ready_out(dn_ready_in),
    .dn_write_in(dn_write_out), .dn_addr_in(dn_addr_out),
    .dn_size_in(dn_size_out), .dn_wdata_in(dn_wdata_out),
    .dn_rvalid_out(dn_rvalid_in), .dn_rdata_out(dn_rdata_in),
    .dn_err_out(dn_err_in));
  initial forever #4 core_clk_in = ~core_clk_in;
  // a fabric stalling every other cycle makes some requests wait on ready
  always @(negedge core_clk_in) stall <= ~stall;
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_req(input bbr_row_s r);
    int n;
    {up_write_in, up_instr_in, up_addr_in} = {r.w, r.f, r.a};
    {up_size_in, up_wdata_in, up_valid_in} = {r.s, r.wd, 1'b1};
    n = 0;
    while (up_ready_out !== 1'b1 && n < 50)
    begin
      @(negedge core_clk_in);
      n++;
    end
    @(negedge core_clk_in);
    up_valid_in = 1'b0;
    n = 0;
    while (up_rvalid_out !== 1'b1 && n < 100)
    begin
      @(negedge core_clk_in);
      n++;
    end
    // a request that never gets its answer must not slip through
    if (up_rvalid_out !== 1'b1)
    begin
      error_cnt++;
    end
  endtask
  initial
  begin
    repeat (3) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    foreach (rows[i])
    begin
      do_req(rows[i]);
      `CHK("rdata", rows[i].rd, up_rdata_out)
      `CHK("err", rows[i].er, up_err_out)
    end
    @(negedge core_clk_in);
    reset_n_in = 1'b0;
    @(negedge core_clk_in);
    `CHK("ready", 1'b1, up_ready_out)
    `CHK("dn_valid", 1'b0, dn_valid_out)
    `CHK("dn_size", bbr_pkg::SIZE_WORD, dn_size_out)
    reset_n_in = 1'b1;
    do_req(rows[2]);
    `CHK("rdata", 32'h0000_0000, up_rdata_out)
    complete_run;
  end
  initial
  begin
    #(4000 * 8);
    error_cnt++;
    complete_run;
  end
endmodule
bind bbr_remap bbr_remap_props u_props (.core_clk_in, .reset_n_in,
  .up_valid_in, .up_ready_out, .up_write_in, .up_instr_in, .up_addr_in,
  .up_size_in, .up_wdata_in, .up_rvalid_out, .up_rdata_out, .up_err_out,
  .dn_valid_out, .dn_ready_in, .dn_write_out, .dn_instr_out, .dn_lock_out,
  .dn_addr_out, .dn_size_out, .dn_wdata_out);
`default_nettype wire
